// File: shared/bfss_defs.svh
/*
 * constants for the boost fault and shutdown supervisor: timing figures, cycle counts and the counter width.
 * assumes a 125 MHz supervisor clock; includers use the macros only.
 */
`ifndef BFSS_DEFS_SVH
`define BFSS_DEFS_SVH

`define BFSS_CLK_MHZ 125
`define BFSS_UNDERVOLTAGE_LOCKOUT_DEGLITCH_US 50
`define BFSS_UNDERVOLTAGE_LOCKOUT_CYCLES (`BFSS_UNDERVOLTAGE_LOCKOUT_DEGLITCH_US * `BFSS_CLK_MHZ)
`define BFSS_FREQ_SET_PIN_LOW_US 7
`define BFSS_FREQ_SET_PIN_CYCLES (`BFSS_FREQ_SET_PIN_LOW_US * `BFSS_CLK_MHZ)
`define BFSS_DIM_LOW_CLOCKS 32750
`define BFSS_CNT_W 16

`endif

// File: shared/bfss_pkg.sv
/*
 * types for the boost fault and shutdown supervisor.
 * assumes bfss_defs.svh supplies widths.
 */
`include "bfss_defs.svh"
package bfss_pkg;

    typedef enum logic [1:0] {
        BFSS_OFF,
        BFSS_DETECT,
        BFSS_RUN
    } bfss_state_t;

    typedef struct packed {
        logic switch_node_ovp;
        logic output_overvoltage_guard;
        logic output_low;
        logic sw_current_limit;
        logic secondary_switch_current_limit;
        logic input_overcurrent;
        logic vin_above_rise;
        logic input_sense_node_above_rise;
        logic vin_below_fall;
    } bfss_cmp_t;

    typedef struct packed {
        logic boost_enable;
        logic boost_on_time_cut;
        logic sinks_enable;
        logic remove_open_strings;
        logic gate_on;
        logic fault_b;
        logic shutdown;
    } bfss_ctl_t;

    typedef struct packed {
        bfss_state_t state;
        logic undervoltage_lockout_ok;
        logic ovp_halt;
        logic sw_latched;
        logic oc_latched;
        logic [`BFSS_CNT_W-1:0] dim_cnt;
        logic [`BFSS_CNT_W-1:0] uv_cnt;
        logic [`BFSS_CNT_W-1:0] freq_set_pin_cnt;
        bfss_ctl_t ctl;
    } bfss_reg_t;

endpackage : bfss_pkg

// File: src/bfss_supervisor.sv
/*
 * fault supervision and shutdown control for a boost led backlight driver.
 * assumes comparator outputs and pin levels already synchronous to clk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "bfss_defs.svh"

module bfss_supervisor
    import bfss_pkg::*;
#(
    parameter int unsigned DIM_LOW_CLOCKS = `BFSS_DIM_LOW_CLOCKS,
    parameter int unsigned UNDERVOLTAGE_LOCKOUT_CYCLES = `BFSS_UNDERVOLTAGE_LOCKOUT_CYCLES,
    parameter int unsigned FREQ_SET_PIN_CYCLES = `BFSS_FREQ_SET_PIN_CYCLES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // external controller pins
    input wire logic dim_in,
    input wire logic freq_set_pin,
    // analog comparators and led detection done
    input wire bfss_cmp_t cmp,
    input wire logic led_detect_done,
    // controls
    output bfss_ctl_t ctl
);

    localparam int unsigned CW = `BFSS_CNT_W;

    bfss_reg_t r_q;
    bfss_reg_t r_d;
    logic fast_off;
    logic dim_off;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        r_d = r_q;
        fast_off = 1'b0;
        dim_off = 1'b0;
        // dimming low counter
        if (dim_in)
        begin
            r_d.dim_cnt = '0;
        end
        else if (r_q.dim_cnt <= CW'(DIM_LOW_CLOCKS))
        begin
            r_d.dim_cnt = r_q.dim_cnt + CW'(1);
        end
        dim_off = !dim_in && (r_q.dim_cnt >= CW'(DIM_LOW_CLOCKS));
        // undervoltage deglitch
        if (!cmp.vin_below_fall)
        begin
            r_d.uv_cnt = '0;
        end
        else if (r_q.uv_cnt <= CW'(UNDERVOLTAGE_LOCKOUT_CYCLES))
        begin
            r_d.uv_cnt = r_q.uv_cnt + CW'(1);
        end
        if (cmp.vin_below_fall && r_q.uv_cnt >= CW'(UNDERVOLTAGE_LOCKOUT_CYCLES))
        begin
            r_d.undervoltage_lockout_ok = 1'b0;
        end
        else if (cmp.vin_above_rise && cmp.input_sense_node_above_rise)
        begin
            r_d.undervoltage_lockout_ok = 1'b1;
        end
        // frequency-set low filter
        if (freq_set_pin)
        begin
            r_d.freq_set_pin_cnt = '0;
        end
        else if (r_q.freq_set_pin_cnt <= CW'(FREQ_SET_PIN_CYCLES))
        begin
            r_d.freq_set_pin_cnt = r_q.freq_set_pin_cnt + CW'(1);
        end
        fast_off = !freq_set_pin && (r_q.freq_set_pin_cnt >= CW'(FREQ_SET_PIN_CYCLES));
        // latched faults
        if (dim_off || !r_q.undervoltage_lockout_ok)
        begin
            r_d.sw_latched = 1'b0;
            r_d.oc_latched = 1'b0;
        end
        if (r_q.state == BFSS_RUN && cmp.switch_node_ovp)
        begin
            r_d.sw_latched = 1'b1;
        end
        if (cmp.secondary_switch_current_limit || cmp.input_overcurrent)
        begin
            r_d.oc_latched = 1'b1;
        end
        // output overvoltage halt, auto restart
        if (cmp.output_overvoltage_guard)
        begin
            r_d.ovp_halt = 1'b1;
        end
        else if (cmp.output_low)
        begin
            r_d.ovp_halt = 1'b0;
        end
        // operating state
        case (r_q.state)
            BFSS_OFF:
            begin
                if (dim_in && r_q.undervoltage_lockout_ok && !fast_off)
                begin
                    r_d.state = BFSS_DETECT;
                end
            end
            BFSS_DETECT:
            begin
                if (led_detect_done)
                begin
                    r_d.state = BFSS_RUN;
                end
            end
            BFSS_RUN:
            begin
            end
            default:
            begin
                r_d.state = BFSS_OFF;
            end
        endcase
        if (dim_off || !r_q.undervoltage_lockout_ok || fast_off)
        begin
            r_d.state = BFSS_OFF;
        end
        // outputs
        r_d.ctl.shutdown = (r_d.state == BFSS_OFF);
        r_d.ctl.fault_b = !r_d.oc_latched && !r_d.sw_latched;
        r_d.ctl.gate_on = !r_d.ctl.shutdown && !r_d.oc_latched && !r_d.sw_latched;
        r_d.ctl.boost_enable = r_d.ctl.gate_on && dim_in && !r_d.ovp_halt;
        r_d.ctl.sinks_enable = r_d.ctl.gate_on && dim_in;
        r_d.ctl.remove_open_strings = cmp.output_overvoltage_guard;
        r_d.ctl.boost_on_time_cut = cmp.sw_current_limit;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            r_q <= '{state: BFSS_OFF, undervoltage_lockout_ok: 1'b0, ovp_halt: 1'b0, sw_latched: 1'b0,
                     oc_latched: 1'b0, dim_cnt: '0, uv_cnt: '0, freq_set_pin_cnt: '0,
                     ctl: '{boost_enable: 1'b0, boost_on_time_cut: 1'b0, sinks_enable: 1'b0,
                            remove_open_strings: 1'b0, gate_on: 1'b0, fault_b: 1'b1,
                            shutdown: 1'b1}};
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign ctl = r_q.ctl;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_ovp_no_latch;
        @(posedge clk) disable iff (!rst_b)
        cmp.output_overvoltage_guard ##1 (!cmp.output_overvoltage_guard && cmp.output_low) |=> !r_q.ovp_halt;
    endproperty
    a_ovp_no_latch: assert property (p_ovp_no_latch) else $error("overvoltage halt stuck");

    property p_ovp_halts;
        @(posedge clk) disable iff (!rst_b)
        cmp.output_overvoltage_guard |=> !ctl.boost_enable;
    endproperty
    a_ovp_halts: assert property (p_ovp_halts) else $error("boost ran during overvoltage");

    property p_open_string;
        @(posedge clk) disable iff (!rst_b)
        cmp.output_overvoltage_guard |=> ctl.remove_open_strings;
    endproperty
    a_open_string: assert property (p_open_string) else $error("open string not removed");

    property p_sw_latch;
        @(posedge clk) disable iff (!rst_b)
        (r_q.state == BFSS_RUN && cmp.switch_node_ovp && r_q.undervoltage_lockout_ok && !dim_off) |=>
            (!ctl.gate_on && !ctl.fault_b);
    endproperty
    a_sw_latch: assert property (p_sw_latch) else $error("switch node fault not latched");

    property p_oc_trip;
        @(posedge clk) disable iff (!rst_b)
        cmp.input_overcurrent |=> (!ctl.fault_b && !ctl.gate_on && !ctl.sinks_enable);
    endproperty
    a_oc_trip: assert property (p_oc_trip) else $error("input overcurrent not tripped");

    property p_cur_limit;
        @(posedge clk) disable iff (!rst_b)
        cmp.sw_current_limit |=> ctl.boost_on_time_cut;
    endproperty
    a_cur_limit: assert property (p_cur_limit) else $error("on-time not cut");

    property p_dim_low;
        @(posedge clk) disable iff (!rst_b)
        !dim_in |=> !ctl.sinks_enable;
    endproperty
    a_dim_low: assert property (p_dim_low) else $error("sinks on while dimming low");

    property p_dim_cnt;
        @(posedge clk) disable iff (!rst_b)
        dim_in |=> (r_q.dim_cnt == '0);
    endproperty
    a_dim_cnt: assert property (p_dim_cnt) else $error("dimming counter not restarted");

    property p_fast_off;
        @(posedge clk) disable iff (!rst_b)
        fast_off |=> (ctl.shutdown && !ctl.gate_on);
    endproperty
    a_fast_off: assert property (p_fast_off) else $error("fast shutdown missed");

    // ------------------------------------------------------------
    // fault and shutdown sequences
    // ------------------------------------------------------------
    sequence s_tripped;
        !ctl.fault_b && !ctl.gate_on && !ctl.boost_enable && !ctl.sinks_enable;
    endsequence

    sequence s_off_quiet;
        ctl.shutdown && !ctl.gate_on && !ctl.sinks_enable && !ctl.boost_enable;
    endsequence

    sequence s_uv_drop;
        !r_q.undervoltage_lockout_ok ##1 s_off_quiet;
    endsequence

    sequence s_dim_clear;
        dim_off && !cmp.secondary_switch_current_limit && !cmp.input_overcurrent &&
            !(r_q.state == BFSS_RUN && cmp.switch_node_ovp);
    endsequence

    property p_sec_trip;
        @(posedge clk) disable iff (!rst_b)
        cmp.secondary_switch_current_limit |=> s_tripped;
    endproperty
    a_sec_trip: assert property (p_sec_trip) else $error("secondary limit not tripped");

    property p_ioc_flag;
        @(posedge clk) disable iff (!rst_b)
        cmp.input_overcurrent |=> !ctl.fault_b;
    endproperty
    a_ioc_flag: assert property (p_ioc_flag) else $error("fault flag not low");

    property p_ioc_gate;
        @(posedge clk) disable iff (!rst_b)
        cmp.input_overcurrent |=> !ctl.gate_on;
    endproperty
    a_ioc_gate: assert property (p_ioc_gate) else $error("disconnect gate still on");

    property p_oc_hold;
        @(posedge clk) disable iff (!rst_b)
        (r_q.oc_latched && r_q.undervoltage_lockout_ok && !dim_off) |=> s_tripped;
    endproperty
    a_oc_hold: assert property (p_oc_hold) else $error("overcurrent latch released");

    property p_sw_trip;
        @(posedge clk) disable iff (!rst_b)
        (r_q.state == BFSS_RUN && cmp.switch_node_ovp) |=> s_tripped;
    endproperty
    a_sw_trip: assert property (p_sw_trip) else $error("switch node trip missed");

    property p_sw_early;
        @(posedge clk) disable iff (!rst_b)
        (r_q.state != BFSS_RUN && !r_q.sw_latched) |=> !r_q.sw_latched;
    endproperty
    a_sw_early: assert property (p_sw_early) else $error("switch node fault before detection");

    property p_sw_hold;
        @(posedge clk) disable iff (!rst_b)
        (r_q.sw_latched && r_q.undervoltage_lockout_ok && !dim_off) |=> r_q.sw_latched;
    endproperty
    a_sw_hold: assert property (p_sw_hold) else $error("switch node latch released");

    property p_dim_clear;
        @(posedge clk) disable iff (!rst_b)
        s_dim_clear |=> (!r_q.sw_latched && !r_q.oc_latched && ctl.fault_b);
    endproperty
    a_dim_clear: assert property (p_dim_clear) else $error("latches kept in shutdown");

    property p_dim_off;
        @(posedge clk) disable iff (!rst_b)
        dim_off |=> s_off_quiet;
    endproperty
    a_dim_off: assert property (p_dim_off) else $error("dimming shutdown missed");

    property p_uv_clear;
        @(posedge clk) disable iff (!rst_b)
        (!r_q.undervoltage_lockout_ok && !cmp.secondary_switch_current_limit && !cmp.input_overcurrent &&
            !(r_q.state == BFSS_RUN && cmp.switch_node_ovp)) |=> ctl.fault_b;
    endproperty
    a_uv_clear: assert property (p_uv_clear) else $error("fault kept under undervoltage");

    property p_uv_on;
        @(posedge clk) disable iff (!rst_b)
        (cmp.vin_above_rise && cmp.input_sense_node_above_rise && !cmp.vin_below_fall) |=> r_q.undervoltage_lockout_ok;
    endproperty
    a_uv_on: assert property (p_uv_on) else $error("undervoltage enable missed");

    property p_uv_glitch;
        @(posedge clk) disable iff (!rst_b)
        (r_q.undervoltage_lockout_ok && r_q.uv_cnt < CW'(UNDERVOLTAGE_LOCKOUT_CYCLES)) |=> r_q.undervoltage_lockout_ok;
    endproperty
    a_uv_glitch: assert property (p_uv_glitch) else $error("short supply dip disabled");

    property p_uv_off;
        @(posedge clk) disable iff (!rst_b)
        (cmp.vin_below_fall && r_q.uv_cnt >= CW'(UNDERVOLTAGE_LOCKOUT_CYCLES)) |=> s_uv_drop;
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("undervoltage disable missed");

    property p_uv_cnt;
        @(posedge clk) disable iff (!rst_b)
        !cmp.vin_below_fall |=> (r_q.uv_cnt == '0);
    endproperty
    a_uv_cnt: assert property (p_uv_cnt) else $error("deglitch counter not restarted");

    property p_freq_set_pin_cnt;
        @(posedge clk) disable iff (!rst_b)
        freq_set_pin |=> (r_q.freq_set_pin_cnt == '0);
    endproperty
    a_freq_set_pin_cnt: assert property (p_freq_set_pin_cnt) else $error("freq_set_pin counter not restarted");

    property p_off_wait;
        @(posedge clk) disable iff (!rst_b)
        (r_q.state == BFSS_OFF && !dim_in) |=> (r_q.state == BFSS_OFF);
    endproperty
    a_off_wait: assert property (p_off_wait) else $error("woke without dimming high");

    property p_off_dark;
        @(posedge clk) disable iff (!rst_b)
        ctl.shutdown |-> !ctl.sinks_enable;
    endproperty
    a_off_dark: assert property (p_off_dark) else $error("sinks on in shutdown");

    property p_cut_next;
        @(posedge clk) disable iff (!rst_b)
        !cmp.sw_current_limit |=> !ctl.boost_on_time_cut;
    endproperty
    a_cut_next: assert property (p_cut_next) else $error("on-time cut held over");

    property p_ovp_no_fault;
        @(posedge clk) disable iff (!rst_b)
        (cmp.output_overvoltage_guard && !r_q.oc_latched && !r_q.sw_latched &&
            !cmp.secondary_switch_current_limit && !cmp.input_overcurrent &&
            !(r_q.state == BFSS_RUN && cmp.switch_node_ovp)) |=> (ctl.fault_b && r_q.ovp_halt);
    endproperty
    a_ovp_no_fault: assert property (p_ovp_no_fault) else $error("overvoltage raised a fault");

endmodule : bfss_supervisor
`default_nettype wire

// File: tb/bfss_ctrl_model.sv
/* external controller model: drives dimming and frequency-set pins.
   assumes bench requests; pins follow one clock later. */
`timescale 1ns/10ps
`default_nettype none
module bfss_ctrl_model
(
    // clock
    input wire logic clk,
    // bench requests
    input wire logic dim_req,
    input wire logic freq_set_pin_low_req,
    // pins
    output logic dim_in,
    output logic freq_set_pin
);
    // ---------
    // pin drive
    // ---------
    always @(posedge clk)
    begin
        dim_in <= dim_req;
        freq_set_pin <= ~freq_set_pin_low_req;
    end
endmodule : bfss_ctrl_model
`default_nettype wire

// File: tb/bfss_supervisor_tb_top.sv
/* bench for the boost fault and shutdown supervisor.
   assumes shortened counts and the controller model. */
`timescale 1ns/10ps
`default_nettype none
module bfss_supervisor_tb_top
    import bfss_pkg::*;
;
    localparam int DIM = 20;
    localparam int UV = 10;
    localparam int FS = 8;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic dim_req = 1'b0;
    logic freq_set_pin_low_req = 1'b0;
    logic led_detect_done = 1'b0;
    bfss_cmp_t cmp = '0;
    logic dim_in;
    logic freq_set_pin;
    bfss_ctl_t ctl;
    bfss_ctl_t ctl_raw;
    int n_errors = 0;
    int comparisons = 0;

    bfss_ctrl_model bfss_ctrl_model_inst (.clk(clk), .dim_req(dim_req), .freq_set_pin_low_req(freq_set_pin_low_req),
        .dim_in(dim_in), .freq_set_pin(freq_set_pin));
    bfss_supervisor #(.DIM_LOW_CLOCKS(DIM), .UNDERVOLTAGE_LOCKOUT_CYCLES(UV), .FREQ_SET_PIN_CYCLES(FS)) bfss_supervisor_inst (
        .clk(clk), .rst_b(rst_b), .dim_in(dim_in), .freq_set_pin(freq_set_pin), .cmp(cmp),
        .led_detect_done(led_detect_done), .ctl(ctl_raw));

    // settled copy, so checks at a rising edge never race the flops
    always @(negedge clk)
        ctl <= ctl_raw;

    // -------
    // helpers
    // -------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic chk(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: ctl bit %b, expected %b", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("errors %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    // ---------
    // scenarios
    // ---------
    task automatic t_power_up();
        led_detect_done <= 1'b0;
        cmp.vin_above_rise <= 1'b1;
        cmp.input_sense_node_above_rise <= 1'b1;
        dim_req <= 1'b1;
        cmp.switch_node_ovp <= 1'b1;
        cyc(5);
        cmp.switch_node_ovp <= 1'b0;
        led_detect_done <= 1'b1;
        cyc(4);
        chk(ctl.boost_enable, 1'b1);
        chk(ctl.fault_b, 1'b1);
        chk(ctl.sinks_enable, 1'b1);
        chk(ctl.gate_on, 1'b1);
    endtask : t_power_up
    task automatic t_ovp();
        cmp.output_overvoltage_guard <= 1'b1;
        cyc(3);
        chk(ctl.boost_enable, 1'b0);
        chk(ctl.remove_open_strings, 1'b1);
        chk(ctl.shutdown, 1'b0);
        cmp.output_overvoltage_guard <= 1'b0;
        cmp.output_low <= 1'b1;
        cyc(3);
        chk(ctl.boost_enable, 1'b1);
        chk(ctl.fault_b, 1'b1);
        cmp.output_low <= 1'b0;
        cmp.output_overvoltage_guard <= 1'b1;
        cyc(3);
        chk(ctl.boost_enable, 1'b0);
        cmp.output_overvoltage_guard <= 1'b0;
        cmp.output_low <= 1'b1;
        cmp.vin_below_fall <= 1'b1;
        cyc(UV - 4);
        cmp.vin_below_fall <= 1'b0;
        cyc(3);
        chk(ctl.boost_enable, 1'b1);
        cmp.output_low <= 1'b0;
    endtask : t_ovp
    task automatic t_climit();
        cmp.sw_current_limit <= 1'b1;
        cyc(3);
        chk(ctl.boost_on_time_cut, 1'b1);
        chk(ctl.gate_on, 1'b1);
        cmp.sw_current_limit <= 1'b0;
        cyc(3);
        chk(ctl.boost_on_time_cut, 1'b0);
    endtask : t_climit
    task automatic t_ioc();
        cmp.input_overcurrent <= 1'b1;
        cyc(1);
        cmp.input_overcurrent <= 1'b0;
        cyc(3);
        chk(ctl.fault_b, 1'b0);
        chk(ctl.gate_on, 1'b0);
        chk(ctl.boost_enable, 1'b0);
        dim_req <= 1'b0;
        cyc(DIM - 4);
        dim_req <= 1'b1;
        cyc(2);
        dim_req <= 1'b0;
        cyc(DIM - 4);
        chk(ctl.fault_b, 1'b0);
        cyc(10);
        chk(ctl.fault_b, 1'b1);
        chk(ctl.sinks_enable, 1'b0);
        t_power_up();
    endtask : t_ioc
    task automatic t_sec();
        cmp.secondary_switch_current_limit <= 1'b1;
        cyc(3);
        chk(ctl.fault_b, 1'b0);
        chk(ctl.gate_on, 1'b0);
        cmp.secondary_switch_current_limit <= 1'b0;
        dim_req <= 1'b0;
        cyc(DIM + 8);
        t_power_up();
    endtask : t_sec
    task automatic t_swovp();
        cmp.switch_node_ovp <= 1'b1;
        cyc(3);
        chk(ctl.boost_enable, 1'b0);
        cmp.switch_node_ovp <= 1'b0;
        cyc(3);
        chk(ctl.sinks_enable, 1'b0);
        cmp.vin_above_rise <= 1'b0;
        cmp.input_sense_node_above_rise <= 1'b0;
        cmp.vin_below_fall <= 1'b1;
        cyc(UV + 6);
        chk(ctl.shutdown, 1'b1);
        chk(ctl.fault_b, 1'b1);
        cmp.vin_below_fall <= 1'b0;
        t_power_up();
    endtask : t_swovp
    task automatic t_freq_set_pin();
        freq_set_pin_low_req <= 1'b1;
        cyc(FS - 3);
        freq_set_pin_low_req <= 1'b0;
        cyc(3);
        chk(ctl.boost_enable, 1'b1);
        freq_set_pin_low_req <= 1'b1;
        cyc(FS + 6);
        chk(ctl.boost_enable, 1'b0);
        chk(ctl.gate_on, 1'b0);
        chk(ctl.sinks_enable, 1'b0);
        freq_set_pin_low_req <= 1'b0;
    endtask : t_freq_set_pin

    // ----
    // main
    // ----
    initial
    begin
        forever #4 clk = ~clk;
    end
    initial
    begin
        #100000;
        n_errors++;
        stop_test();
    end
    initial
    begin
        cyc(8);
        chk(ctl.shutdown, 1'b1);
        rst_b <= 1'b1;
        t_power_up();
        t_ovp();
        t_climit();
        t_ioc();
        t_sec();
        t_swovp();
        t_freq_set_pin();
        stop_test();
    end
endmodule : bfss_supervisor_tb_top
`default_nettype wire
